// File: core/chgst_status.sv
// Charger state and fault status register with its access port
//
// How it works
// - Bit 15 follows charger-ok: 1 while an input source is present.
// - Bit 14 is 1 once the input power optimizer has finished.
// - Bit 13 is 1 while the charger runs in peak-assist mode.
// - Bit 12 is 1 while input voltage limiting or reverse regulation is on.
// - Bit 11 is 1 while input current limiting is active.
// - Bit 10 is 1 while charging in the fast charge phase.
// - Bit 9 is 1 while charging in the pre-charge phase.
// - Bit 8 is 1 while power flows from the battery to the input port.
// - Fault bits 7, 6, 5, 2, 1 and 0 latch on their fault; a read clears.
// - Bit 4 latches on system overvoltage and holds the converter off.
// - Writing 0 to bit 4 or removing the adapter clears it and the hold.
// - Bit 3 sets after seven failed restarts in a row with the rail low.
// - Bit 3 clears only by a host write of 0; a read leaves it set.
// - The whole register is zero after reset.
`timescale 1ns/1ps
`include "chgst_map.svh"

module chgst_status
	import chgst_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	input  wire logic        charger_ok_indicator,
	input  wire logic        optimizer_done_flag,
	input  wire logic        peak_assist_active,
	input  wire logic        voltage_limit_active,
	input  wire logic        current_limit_active,
	input  wire logic        fast_charge_active,
	input  wire logic        precharge_active,
	input  wire logic        reverse_mode_active,
	input  wire logic        input_overvoltage_fault,
	input  wire logic        battery_overcurrent_fault,
	input  wire logic        input_overcurrent_fault,
	input  wire logic        latchoff_fault,
	input  wire logic        reverse_overvoltage_fault,
	input  wire logic        reverse_undervoltage_fault,
	input  wire logic        system_overvoltage_cond,
	input  wire logic        system_rail_low,
	input  wire logic        restart_failed,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	output logic      [15:0] charger_state_and_faults,
	output logic             converter_disable
);

	logic [16:0]     sync_w;
	logic [7:0]      live_r;
	logic [7:0]      flt_r;
	logic [7:0]      flt_nxt;
	logic            ok_prev_r;
	logic            fail_prev_r;
	logic [2:0]      retry_r;
	logic [2:0]      retry_nxt;
	chgst_retry_type rt_r;
	chgst_retry_type rt_nxt;
	logic            short_trip;

	chgst_sync #(
		.W(`CHGST_SYNC_WIDTH)
	) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.async_in ({restart_failed, system_rail_low,
			system_overvoltage_cond, reverse_undervoltage_fault,
			reverse_overvoltage_fault, latchoff_fault,
			input_overcurrent_fault, battery_overcurrent_fault,
			input_overvoltage_fault, reverse_mode_active,
			precharge_active, fast_charge_active,
			current_limit_active, voltage_limit_active,
			peak_assist_active, optimizer_done_flag,
			charger_ok_indicator}),
		.sync_out (sync_w)
	);

	wire [7:0] live_nxt = {sync_w[0], sync_w[1], sync_w[2], sync_w[3],
		sync_w[4], sync_w[5], sync_w[6], sync_w[7]};
	wire       ok_s     = sync_w[0];
	wire       sysov_s  = sync_w[14];
	wire       low_s    = sync_w[15];
	wire       fail_s   = sync_w[16];

	wire addr_hit = (reg_addr == `CHGST_ADDR_STATUS);
	wire rd_hit   = reg_rd && addr_hit;
	wire wr_hit   = reg_wr && addr_hit;

	// Rising edge of a failed restart attempt
	wire fail_pulse = fail_s && !fail_prev_r;
	// Adapter unplug seen as falling charger-ok
	wire adapter_gone = ok_prev_r && !ok_s;

	// Set sources, one per fault bit position
	wire [7:0] set_vec = {sync_w[8], sync_w[9], sync_w[10], sysov_s,
		short_trip, sync_w[11], sync_w[12], sync_w[13]};

	wire [7:0] rd_clr = rd_hit ? `CHGST_RDCLR_MASK : 8'h00;
	wire [7:0] wr_clr = wr_hit ? (~reg_wdata[7:0] & `CHGST_WRCLR_MASK)
		: 8'h00;
	wire [7:0] rm_clr = adapter_gone ? `CHGST_SYSOV_MASK : 8'h00;

	// A set arriving with a clear wins
	assign flt_nxt = (flt_r & ~(rd_clr | wr_clr | rm_clr)) | set_vec;

	assign charger_state_and_faults = {live_r, flt_r};
	assign converter_disable        = flt_r[`CHGST_BIT_SYS_OV];

	// Restart monitor: counts consecutive failures while the rail is low
	always_comb begin
		rt_nxt     = rt_r;
		retry_nxt  = retry_r;
		short_trip = 1'b0;
		case (rt_r)
			CHGST_RT_IDLE: begin
				retry_nxt = `CHGST_RETRY_ZERO;
				if (low_s && fail_pulse) begin
					retry_nxt = `CHGST_RETRY_ONE;
					rt_nxt    = CHGST_RT_COUNT;
				end
			end
			CHGST_RT_COUNT: begin
				if (!low_s) begin
					rt_nxt    = CHGST_RT_IDLE;
					retry_nxt = `CHGST_RETRY_ZERO;
				end else if (fail_pulse) begin
					retry_nxt = retry_r + `CHGST_RETRY_ONE;
					if (retry_nxt == `CHGST_RETRY_LIMIT) begin
						rt_nxt = CHGST_RT_TRIP;
					end
				end
			end
			CHGST_RT_TRIP: begin
				short_trip = 1'b1;
				rt_nxt     = CHGST_RT_IDLE;
				retry_nxt  = `CHGST_RETRY_ZERO;
			end
			default: begin
				rt_nxt    = CHGST_RT_IDLE;
				retry_nxt = `CHGST_RETRY_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			live_r      <= `CHGST_LIVE_RESET;
			flt_r       <= `CHGST_FLT_RESET;
			ok_prev_r   <= 1'b0;
			fail_prev_r <= 1'b0;
			retry_r     <= `CHGST_RETRY_ZERO;
			rt_r        <= CHGST_RT_IDLE;
		end else if (ce) begin
			live_r      <= live_nxt;
			flt_r       <= flt_nxt;
			ok_prev_r   <= ok_s;
			fail_prev_r <= fail_s;
			retry_r     <= retry_nxt;
			rt_r        <= rt_nxt;
		end
	end

	// Read port: data of the addressed register one cycle after a strobe taken with ce high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata  <= `CHGST_RESET_VALUE;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_rd;
			reg_rdata  <= rd_hit ? charger_state_and_faults
				: `CHGST_RESET_VALUE;
		end else begin
			reg_rvalid <= 1'b0;
		end
	end

	present_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_PRESENT] == $past(ok_s))
		else $error("input present bit does not follow charger ok");
	opt_done_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_OPT_DONE]
		== $past(sync_w[1]))
		else $error("optimizer done bit wrong");
	peak_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_PEAK] == $past(sync_w[2]))
		else $error("peak assist bit wrong");
	vlim_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_VLIM] == $past(sync_w[3]))
		else $error("voltage limit bit wrong");
	ilim_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_ILIM] == $past(sync_w[4]))
		else $error("current limit bit wrong");
	fast_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_FAST] == $past(sync_w[5]))
		else $error("fast charge bit wrong");
	pre_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_PRE] == $past(sync_w[6]))
		else $error("pre-charge bit wrong");
	rev_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> charger_state_and_faults[`CHGST_BIT_REVERSE] == $past(sync_w[7]))
		else $error("reverse mode bit wrong");
	read_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && rd_hit && !sync_w[8] |=> !flt_r[`CHGST_BIT_IN_OV])
		else $error("read did not clear input overvoltage fault");
	fault_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && flt_r[`CHGST_BIT_REV_UV] && !rd_hit |=> flt_r[`CHGST_BIT_REV_UV])
		else $error("fault dropped without a read");
	ovp_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && sysov_s |=> converter_disable)
		else $error("converter not held off in system overvoltage");
	ovp_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && wr_hit && !reg_wdata[`CHGST_BIT_SYS_OV] && !sysov_s
		|=> !converter_disable)
		else $error("write of 0 did not clear system overvoltage");
	short_trip_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && rt_r == CHGST_RT_TRIP |=> flt_r[`CHGST_BIT_SYS_SHORT])
		else $error("short fault not set after retries");
	short_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && flt_r[`CHGST_BIT_SYS_SHORT] && rd_hit && !wr_hit
		|=> flt_r[`CHGST_BIT_SYS_SHORT])
		else $error("read cleared the short fault");
	reset_zero_a: assert property (@(posedge clk)
		sys_rst |=> charger_state_and_faults == `CHGST_RESET_VALUE)
		else $error("register not zero after reset");
	write_one_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce && wr_hit && !rd_hit && reg_wdata[`CHGST_BIT_SYS_SHORT]
		&& !flt_r[`CHGST_BIT_SYS_SHORT] && rt_r != CHGST_RT_TRIP
		|=> !flt_r[`CHGST_BIT_SYS_SHORT])
		else $error("write of 1 set the short fault");

endmodule

// File: core/chgst_map.svh
// Constant map for the charger state and fault register
`ifndef CHGST_MAP_SVH
`define CHGST_MAP_SVH

`define CHGST_ADDR_STATUS    8'h20
`define CHGST_RESET_VALUE    16'h0000
`define CHGST_FLT_RESET      8'h00
`define CHGST_LIVE_RESET     8'h00
`define CHGST_BIT_PRESENT    15
`define CHGST_BIT_OPT_DONE   14
`define CHGST_BIT_PEAK       13
`define CHGST_BIT_VLIM       12
`define CHGST_BIT_ILIM       11
`define CHGST_BIT_FAST       10
`define CHGST_BIT_PRE        9
`define CHGST_BIT_REVERSE    8
`define CHGST_BIT_IN_OV      7
`define CHGST_BIT_BAT_OC     6
`define CHGST_BIT_IN_OC      5
`define CHGST_BIT_SYS_OV     4
`define CHGST_BIT_SYS_SHORT  3
`define CHGST_BIT_LATCHOFF   2
`define CHGST_BIT_REV_OV     1
`define CHGST_BIT_REV_UV     0
`define CHGST_RDCLR_MASK     8'hE7
`define CHGST_WRCLR_MASK     8'h18
`define CHGST_SYSOV_MASK     8'h10
`define CHGST_RETRY_LIMIT    3'h7
`define CHGST_RETRY_ZERO     3'h0
`define CHGST_RETRY_ONE      3'h1
`define CHGST_SYNC_WIDTH     17

`endif

// File: core/chgst_pkg.sv
// Types shared by the charger state and fault register
package chgst_pkg;

	typedef enum logic [1:0] {
		CHGST_RT_IDLE  = 2'b00,
		CHGST_RT_COUNT = 2'b01,
		CHGST_RT_TRIP  = 2'b10
	} chgst_retry_type;

endpackage

// File: core/chgst_sync.sv
// Two-stage synchroniser for asynchronous condition inputs
`timescale 1ns/1ps
`include "chgst_map.svh"

module chgst_sync
	import chgst_pkg::*;
#(
	parameter int W = `CHGST_SYNC_WIDTH
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// File: dv/chgst_host.sv
// Host model driving the register strobe port
`timescale 1ns/1ps

module chgst_host (
	input  wire logic        clk,
	output logic      [7:0]  reg_addr,
	output logic             reg_rd,
	output logic             reg_wr,
	output logic      [15:0] reg_wdata
);
	initial begin
		reg_addr  = 8'h00;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = 16'h0000;
	end
	// One strobe cycle; data is scrambled once released
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [15:0] d);
		reg_addr  = a;
		reg_wdata = d;
		reg_rd    = ~wr;
		reg_wr    = wr;
		@(posedge clk);
		#1;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = ~d;
		reg_addr  = ~a;
		// Idle cycle so a following access never re-raises a strobe at once
		@(posedge clk);
		#1;
	endtask
endmodule

// File: dv/test_charger_status_register.sv
// Self-checking bench for the charger state and fault register
`timescale 1ns/1ps

module test_charger_status_register;
	logic        clk;
	logic        sys_rst;
	logic        ce;
	logic [7:0]  live;
	logic [7:0]  flt;
	logic        sov;
	logic        rail;
	logic        rfail;
	logic [7:0]  reg_addr;
	logic        reg_rd;
	logic        reg_wr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic        conv_off;
	logic [15:0] sts;
	logic [15:0] exp_q[$];
	int          mismatches;
	int          comparisons;
	chgst_host host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata));
	chgst_status dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.charger_ok_indicator(live[7]), .optimizer_done_flag(live[6]),
		.peak_assist_active(live[5]), .voltage_limit_active(live[4]),
		.current_limit_active(live[3]), .fast_charge_active(live[2]),
		.precharge_active(live[1]), .reverse_mode_active(live[0]),
		.input_overvoltage_fault(flt[7]),
		.battery_overcurrent_fault(flt[6]),
		.input_overcurrent_fault(flt[5]), .latchoff_fault(flt[2]),
		.reverse_overvoltage_fault(flt[1]),
		.reverse_undervoltage_fault(flt[0]),
		.system_overvoltage_cond(sov), .system_rail_low(rail),
		.restart_failed(rfail), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .charger_state_and_faults(sts),
		.converter_disable(conv_off));
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		chk("pending_reads", 16'(exp_q.size()), 16'h0000);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 16'h0000);
	endtask
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end
	always @(negedge clk) begin
		if (reg_rvalid === 1'b1)
			chk("reg_rdata", reg_rdata,
				exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
	end
	initial begin
		{live, flt, sov, rail, rfail} = '0;
		sys_rst = 1'b1;
		ce = 1'b1;
		void'($urandom(43970));
		repeat (8) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		rd(8'h20, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			live = 8'($urandom);
			settle();
			chk("charger_state_and_faults", sts, {live, 8'h00});
			rd(8'h20, {live, 8'h00});
		end
		live = 8'h00;
		for (int b = 0; b < 8; b++) begin
			if (b == 3 || b == 4)
				continue;
			flt[b] = 1'b1;
			settle();
			flt[b] = 1'b0;
			settle();
			chk("charger_state_and_faults", sts, 16'(1 << b));
			ce = 1'b0;
			host.access(1'b0, 8'h20, 16'h0000);
			ce = 1'b1;
			rd(8'h20, 16'(1 << b));
			rd(8'h20, 16'h0000);
		end
		sov = 1'b1;
		settle();
		chk("converter_disable", {15'h0000, conv_off}, 16'h0001);
		rd(8'h20, 16'h0010);
		sov = 1'b0;
		settle();
		host.access(1'b1, 8'h20, 16'hFFFF);
		rd(8'h20, 16'h0010);
		host.access(1'b1, 8'h20, 16'h0000);
		settle();
		chk("converter_disable", {15'h0000, conv_off}, 16'h0000);
		rd(8'h20, 16'h0000);
		live[7] = 1'b1;
		sov = 1'b1;
		settle();
		rd(8'h20, 16'h8010);
		sov = 1'b0;
		live[7] = 1'b0;
		settle();
		rd(8'h20, 16'h0000);
		rail = 1'b1;
		for (int n = 1; n <= 7; n++) begin
			rfail = 1'b1;
			settle();
			rfail = 1'b0;
			settle();
			if (n == 6)
				rd(8'h20, 16'h0000);
		end
		settle();
		rd(8'h20, 16'h0008);
		rail = 1'b0;
		settle();
		rd(8'h20, 16'h0008);
		rd(8'h21, 16'h0000);
		host.access(1'b1, 8'h21, 16'h0000);
		host.access(1'b1, 8'h20, 16'h0008);
		rd(8'h20, 16'h0008);
		host.access(1'b1, 8'h20, 16'h0000);
		rd(8'h20, 16'h0000);
		live = 8'hFF;
		settle();
		chk("charger_state_and_faults", sts, 16'hFF00);
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		chk("charger_state_and_faults", sts, 16'h0000);
		rd(8'h20, 16'h0000);
		live = 8'h00;
		settle();
		stop_test();
	end
endmodule
